// [user_break_comparator.sv]
`timescale 1ns/100ps
`include "ubc_cfg.svh"

// Functional notes
// - two channels, A and B, each with own conditions, sharing one break request
// - sequential mode: break only when B matches after A has matched
// - address mask: all bits, ignore low 10, ignore low 12, or excluded
// - space id mask bit 2: 0 compares all eight bits, 1 excludes id
// - 8-bit break id compared with current page entry space id
// - 32-bit virtual bus address compared with channel break address
// - channel B only: masked 32-bit data compare when data enable set
// - qualify by fetch or data, read or write, and operand size
// - per-channel bit picks fetch break before or after execution
// - break sets the channel match flags in common control to 1
// - satisfied condition raises break trap request to the cpu while its channel match flag is 0
// - cycle registers and common control clear to zero on reset
// - address, id, mask, data and data mask keep value over reset
// - all registers retain contents in standby
// - address mask bits 7 to 3 read 0; software writes 0
// - select code 00 drops term; for type and direction 01, 10, 11 pick first, second, both; for size each picks one bus size
// - byte or word size: data bits 31 to 16 ignored
// - data ignored when B breaks on fetch or data enable is 0
module user_break_comparator (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // axi4-lite write address
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] AWADDR,
   input wire logic [2:0] AWPROT,
   // axi4-lite write data
   input wire logic WVALID,
   output logic WREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   // axi4-lite write response
   output logic BVALID,
   input wire logic BREADY,
   output logic [1:0] BRESP,
   // axi4-lite read address
   input wire logic ARVALID,
   output logic ARREADY,
   input wire logic [31:0] ARADDR,
   input wire logic [2:0] ARPROT,
   // axi4-lite read data
   output logic RVALID,
   input wire logic RREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   // cpu bus cycle observed
   input wire logic BUS_VALID,
   input wire logic [31:0] BUS_ADDR,
   input wire logic BUS_FETCH,
   input wire logic BUS_WRITE,
   input wire ubc_pkg::sel_t BUS_SIZE,
   input wire logic [31:0] BUS_DATA,
   // space id from the page entry high register
   input wire logic [7:0] PAGE_SPACE_ID,
   // break request to the cpu
   output logic BREAK_REQ,
   output logic BREAK_AFTER
);
   import ubc_pkg::*;

   // write channel state
   logic aw_hold_q;
   logic w_hold_q;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   // read channel state
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   // channel registers, index 0 is A and 1 is B
   logic [31:0] addr_q [2];
   logic [7:0] space_q [2];
   logic [2:0] mask_q [2];
   logic [5:0] cycle_q [2];
   logic [31:0] data_q;
   logic [31:0] dmask_q;
   // common control fields
   logic [1:0] flag_q;
   logic [1:0] flag_d;
   logic [1:0] timing_q;
   logic data_en_q;
   logic seq_q;
   // sequencing and outputs
   seq_state_t seq_state_q;
   seq_state_t seq_state_d;
   logic break_q;
   logic after_q;

   // byte lane merge for a write
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // bus handshake, one write and one read in flight
   logic do_write;
   logic do_read;
   assign AWREADY = !aw_hold_q && !bvalid_q;
   assign WREADY = !w_hold_q && !bvalid_q;
   assign ARREADY = !rvalid_q;
   assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
   assign do_read = ARVALID && ARREADY;
   assign BVALID = bvalid_q;
   assign BRESP = bresp_q;
   assign RVALID = rvalid_q;
   assign RDATA = rdata_q;
   assign RRESP = rresp_q;

   // write address decode
   logic [1:0] wr_addr;
   logic [1:0] wr_space;
   logic [1:0] wr_mask;
   logic [1:0] wr_cycle;
   logic wr_data;
   logic wr_dmask;
   logic wr_common;
   logic wr_hit;
   assign wr_addr[0] = do_write && awaddr_q == `OFS_ADDR_A;
   assign wr_addr[1] = do_write && awaddr_q == `OFS_ADDR_B;
   assign wr_space[0] = do_write && awaddr_q == `OFS_SPACE_A;
   assign wr_space[1] = do_write && awaddr_q == `OFS_SPACE_B;
   assign wr_mask[0] = do_write && awaddr_q == `OFS_MASK_A;
   assign wr_mask[1] = do_write && awaddr_q == `OFS_MASK_B;
   assign wr_cycle[0] = do_write && awaddr_q == `OFS_CYCLE_A;
   assign wr_cycle[1] = do_write && awaddr_q == `OFS_CYCLE_B;
   assign wr_data = do_write && awaddr_q == `OFS_DATA_B;
   assign wr_dmask = do_write && awaddr_q == `OFS_DMASK_B;
   assign wr_common = do_write && awaddr_q == `OFS_COMMON;
   assign wr_hit = |{wr_addr, wr_space, wr_mask, wr_cycle, wr_data, wr_dmask, wr_common};

   // common control as one word
   logic [15:0] common_rd;
   logic [31:0] common_new;
   always_comb begin
      common_rd = 16'h0000;
      common_rd[`BIT_FLAG_A] = flag_q[0];
      common_rd[`BIT_FLAG_B] = flag_q[1];
      common_rd[`BIT_TIMING_A] = timing_q[0];
      common_rd[`BIT_TIMING_B] = timing_q[1];
      common_rd[`BIT_DATA_EN_B] = data_en_q;
      common_rd[`BIT_SEQ] = seq_q;
   end
   assign common_new = merge({16'h0000, common_rd}, wdata_q, wstrb_q);

   // read mux, unmapped reads answer zero with decode error
   logic [31:0] rd_word;
   logic rd_hit;
   assign rd_hit = ARADDR == `OFS_ADDR_A || ARADDR == `OFS_ADDR_B ||
                   ARADDR == `OFS_SPACE_A || ARADDR == `OFS_SPACE_B ||
                   ARADDR == `OFS_MASK_A || ARADDR == `OFS_MASK_B ||
                   ARADDR == `OFS_CYCLE_A || ARADDR == `OFS_CYCLE_B ||
                   ARADDR == `OFS_DATA_B || ARADDR == `OFS_DMASK_B ||
                   ARADDR == `OFS_COMMON;
   // narrow registers sit low, upper bits read zero
   assign rd_word =
      (ARADDR == `OFS_ADDR_A) ? addr_q[0] :
      (ARADDR == `OFS_ADDR_B) ? addr_q[1] :
      (ARADDR == `OFS_SPACE_A) ? {24'h000000, space_q[0]} :
      (ARADDR == `OFS_SPACE_B) ? {24'h000000, space_q[1]} :
      (ARADDR == `OFS_MASK_A) ? {29'h00000000, mask_q[0]} :
      (ARADDR == `OFS_MASK_B) ? {29'h00000000, mask_q[1]} :
      (ARADDR == `OFS_CYCLE_A) ? {26'h0000000, cycle_q[0]} :
      (ARADDR == `OFS_CYCLE_B) ? {26'h0000000, cycle_q[1]} :
      (ARADDR == `OFS_DATA_B) ? data_q :
      (ARADDR == `OFS_DMASK_B) ? dmask_q :
      (ARADDR == `OFS_COMMON) ? {16'h0000, common_rd} :
      32'h00000000;

   // write channels: address and data taken in either order
   always_ff @(posedge CLK) begin
      if (RST) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= 32'h00000000;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= AWADDR;
         end
         if (WVALID && WREADY) begin
            w_hold_q <= 1'b1;
            wdata_q <= WDATA;
            wstrb_q <= WSTRB;
         end
         if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
         end else if (bvalid_q && BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // read channel, answer one cycle after the address is taken
   always_ff @(posedge CLK) begin
      if (RST) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `RESP_OKAY;
      end else if (do_read) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
      end else if (rvalid_q && RREADY) begin
         rvalid_q <= 1'b0;
      end
   end

   // channel B data registers: no reset, nothing clears them in standby
   always_ff @(posedge CLK) begin
      if (wr_data) begin
         data_q <= merge(data_q, wdata_q, wstrb_q);
      end
      if (wr_dmask) begin
         dmask_q <= merge(dmask_q, wdata_q, wstrb_q);
      end
   end

   // per-channel registers and compare logic
   logic [1:0] hit;
   logic data_ok;
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic [31:0] addr_new;
      logic [31:0] ign;
      logic addr_ok;
      logic id_ok;
      logic type_ok;
      logic dir_ok;
      logic size_ok;
      logic used;
      addr_mask_t am;
      term_sel_t ts;
      term_sel_t ds;
      term_sel_t ss;
      assign addr_new = merge(addr_q[ch], wdata_q, wstrb_q);

      // values survive reset; contents after power-up are undefined
      always_ff @(posedge CLK) begin
         if (wr_addr[ch]) begin
            addr_q[ch] <= addr_new;
         end
         if (wr_space[ch] && wstrb_q[0]) begin // narrow registers sit in byte lane 0
            space_q[ch] <= wdata_q[7:0];
         end
         // only three bits are stored, so bits 7 to 3 read back zero
         if (wr_mask[ch] && wstrb_q[0]) begin
            mask_q[ch] <= wdata_q[2:0];
         end
      end

      // cycle select cleared by reset
      always_ff @(posedge CLK) begin
         if (RST) begin
            cycle_q[ch] <= `CYCLE_RST;
         end else if (wr_cycle[ch] && wstrb_q[0]) begin
            cycle_q[ch] <= wdata_q[5:0];
         end
      end

      assign am = addr_mask_t'(mask_q[ch][`MASK_ADDR_LSB +: 2]);
      assign ts = term_sel_t'(cycle_q[ch][`CYC_TYPE_LSB +: 2]);
      assign ds = term_sel_t'(cycle_q[ch][`CYC_DIR_LSB +: 2]);
      assign ss = term_sel_t'(cycle_q[ch][`CYC_SIZE_LSB +: 2]);
      // low address bits dropped per mask select
      assign ign = (am == AM_LO10) ? `ADDR_IGN_10 :
                   (am == AM_LO12) ? `ADDR_IGN_12 : 32'h00000000;
      assign addr_ok = (am == AM_NONE) ||
                       (((BUS_ADDR ^ addr_q[ch]) & ~ign) == 32'h00000000);
      assign id_ok = mask_q[ch][`MASK_SPACE_BIT] ||
                     (PAGE_SPACE_ID == space_q[ch]);
      // code 00 leaves the term out of the condition
      assign type_ok = (ts == SEL_OFF) || (ts == SEL_BOTH) ||
                       (ts == SEL_FIRST && BUS_FETCH) ||
                       (ts == SEL_SECOND && !BUS_FETCH);
      assign dir_ok = (ds == SEL_OFF) || (ds == SEL_BOTH) ||
                      (ds == SEL_FIRST && !BUS_WRITE) ||
                      (ds == SEL_SECOND && BUS_WRITE);
      assign size_ok = (ss == SEL_OFF) || (ss == BUS_SIZE);
      // an all-zero cycle register would hit every cycle, so it idles the channel
      assign used = cycle_q[ch] != `CYCLE_RST;
      // every included term must hold on the same bus cycle
      assign hit[ch] = BUS_VALID && used && addr_ok && id_ok && type_ok &&
                       dir_ok && size_ok && (ch == 0 || data_ok);
   end

   // channel B data term
   logic [31:0] data_width;
   logic b_fetch_only;
   term_sel_t b_size;
   assign b_size = term_sel_t'(cycle_q[1][`CYC_SIZE_LSB +: 2]);
   // byte and word compare only the low half; software doubles the byte
   assign data_width = (b_size == SEL_FIRST || b_size == SEL_SECOND) ?
                       `DATA_HALF : 32'hffffffff;
   assign b_fetch_only = cycle_q[1][`CYC_TYPE_LSB +: 2] == SEL_FIRST;
   assign data_ok = !data_en_q || b_fetch_only ||
                    (((BUS_DATA ^ data_q) & ~dmask_q & data_width) ==
                     32'h00000000);

   // break decisions; a set flag holds off its channel until software clears it
   logic fire_a;
   logic fire_b;
   logic fire_seq;
   logic fire_any;
   assign fire_a = !seq_q && hit[0] && !flag_q[0];
   assign fire_b = !seq_q && hit[1] && !flag_q[1];
   // a B hit in the arming cycle itself is not after A, so it waits
   assign fire_seq = seq_q && seq_state_q == SEQ_ARMED && hit[1] &&
                     !flag_q[1];
   assign fire_any = fire_a || fire_b || fire_seq;

   // sequence tracking
   always_comb begin
      seq_state_d = seq_state_q;
      unique case (seq_state_q)
         SEQ_IDLE: begin
            if (seq_q && hit[0]) begin
               seq_state_d = SEQ_ARMED;
            end
         end
         SEQ_ARMED: begin
            if (!seq_q || fire_seq) begin
               seq_state_d = SEQ_IDLE;
            end
         end
      endcase
   end

   // flags: hardware set wins over a same-cycle software write
   always_comb begin
      flag_d = flag_q;
      if (wr_common) begin
         flag_d[0] = common_new[`BIT_FLAG_A];
         flag_d[1] = common_new[`BIT_FLAG_B];
      end
      flag_d[0] = flag_d[0] || fire_a || fire_seq;
      flag_d[1] = flag_d[1] || fire_b || fire_seq;
   end

   // common control and sequence state, cleared by reset
   always_ff @(posedge CLK) begin
      if (RST) begin
         flag_q <= {2{`COMMON_BIT_RST}};
         timing_q <= {2{`COMMON_BIT_RST}};
         data_en_q <= `COMMON_BIT_RST;
         seq_q <= `COMMON_BIT_RST;
         seq_state_q <= SEQ_IDLE;
      end else begin
         flag_q <= flag_d;
         seq_state_q <= seq_state_d;
         if (wr_common) begin
            timing_q[0] <= common_new[`BIT_TIMING_A];
            timing_q[1] <= common_new[`BIT_TIMING_B];
            data_en_q <= common_new[`BIT_DATA_EN_B];
            seq_q <= common_new[`BIT_SEQ];
         end
      end
   end

   // trap request one cycle after the matching bus cycle
   always_ff @(posedge CLK) begin
      if (RST) begin
         break_q <= 1'b0;
         after_q <= 1'b0;
      end else begin
         break_q <= fire_any;
         // timing only matters for fetch cycles; data breaks report zero
         after_q <= fire_any && BUS_FETCH &&
                    (fire_a ? timing_q[0] : timing_q[1]);
      end
   end
   assign BREAK_REQ = break_q;
   assign BREAK_AFTER = after_q;

endmodule // user_break_comparator

// [ubc_cfg.svh]
`ifndef UBC_CFG_SVH
`define UBC_CFG_SVH
// register byte addresses
`define OFS_DATA_B 32'h0fffff90
`define OFS_DMASK_B 32'h0fffff94
`define OFS_COMMON 32'h0fffff98
`define OFS_ADDR_B 32'h0fffffa0
`define OFS_CYCLE_B 32'h0fffffa8
`define OFS_ADDR_A 32'h0fffffb0
`define OFS_MASK_A 32'h0fffffb4
`define OFS_CYCLE_A 32'h0fffffb8
`define OFS_SPACE_B 32'h0fffffe8
`define OFS_MASK_B 32'hffffffa4
`define OFS_SPACE_A 32'hffffffe4
// common control field positions
`define BIT_FLAG_A 15
`define BIT_FLAG_B 14
`define BIT_TIMING_A 10
`define BIT_DATA_EN_B 7
`define BIT_TIMING_B 6
`define BIT_SEQ 3
// cycle and mask register fields
`define CYC_TYPE_LSB 4
`define CYC_DIR_LSB 2
`define CYC_SIZE_LSB 0
`define MASK_SPACE_BIT 2
`define MASK_ADDR_LSB 0
// reset values and masks
`define CYCLE_RST 6'h00
`define COMMON_BIT_RST 1'b0
`define ADDR_IGN_10 32'h000003ff
`define ADDR_IGN_12 32'h00000fff
`define DATA_HALF 32'h0000ffff
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// [ubc_pkg.sv]
package ubc_pkg;
   typedef logic [1:0] sel_t;
   // address mask select codes
   typedef enum logic [1:0] {
      AM_FULL = 2'b00,
      AM_LO10 = 2'b01,
      AM_LO12 = 2'b10,
      AM_NONE = 2'b11
   } addr_mask_t;
   // cycle type, direction and size select codes
   typedef enum logic [1:0] {
      SEL_OFF = 2'b00,
      SEL_FIRST = 2'b01,
      SEL_SECOND = 2'b10,
      SEL_BOTH = 2'b11
   } term_sel_t;
   // sequential break tracking
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b01,
      SEQ_ARMED = 2'b10
   } seq_state_t;
endpackage

// [user_break_comparator_asserts.sv]
`timescale 1ns/100ps
// port-level checks on break requests and the register bus
module user_break_comparator_asserts (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // register bus
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic [1:0] BRESP,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic [31:0] RDATA,
   input wire logic [1:0] RRESP,
   // cpu side
   input wire logic BUS_VALID,
   input wire logic BUS_FETCH,
   input wire logic BREAK_REQ,
   input wire logic BREAK_AFTER
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   // a trap request only ever follows an observed bus cycle
   a_req_cause: assert property (BREAK_REQ |-> $past(BUS_VALID))
      else $error("break request without a bus cycle");
   a_after_fetch: assert property (BREAK_AFTER |-> BREAK_REQ && $past(BUS_FETCH))
      else $error("after-execution break not tied to a fetch");
   a_reset_quiet: assert property (@(posedge CLK) disable iff (1'b0) RST |=> !BREAK_REQ && !BVALID && !RVALID)
      else $error("outputs active after reset");
   // register bus answers and holds
   a_read_lat: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read answer late");
   a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
      else $error("read answer dropped or changed");
   a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write answer dropped or changed");
   a_read_block: assert property (RVALID |-> !ARREADY)
      else $error("read taken while answer pending");
   a_write_block: assert property (BVALID |-> !AWREADY && !WREADY)
      else $error("write taken while answer pending");
   a_write_resp: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID)
      else $error("write answer missing");

   c_after: cover property (BREAK_REQ && BREAK_AFTER);
   c_decerr: cover property (RVALID && RRESP == 2'h3);
   c_bstall: cover property (BVALID && !BREADY);
endmodule // user_break_comparator_asserts

bind user_break_comparator user_break_comparator_asserts u_user_break_comparator_asserts (
   .CLK(CLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
   .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
   .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
   .BUS_VALID(BUS_VALID), .BUS_FETCH(BUS_FETCH), .BREAK_REQ(BREAK_REQ),
   .BREAK_AFTER(BREAK_AFTER));

// [cpu_bus_model.sv]
`timescale 1ns/100ps
// cpu core and mmu as seen by the comparator
module cpu_bus_model (
   // clock
   input wire logic CLK,
   // observed bus cycle
   output logic BUS_VALID,
   output logic [31:0] BUS_ADDR,
   output logic BUS_FETCH,
   output logic BUS_WRITE,
   output ubc_pkg::sel_t BUS_SIZE,
   output logic [31:0] BUS_DATA,
   // current space id
   output logic [7:0] PAGE_SPACE_ID,
   // trap request back
   input wire logic BREAK_REQ,
   input wire logic BREAK_AFTER
);
   import ubc_pkg::*;
   initial begin
      BUS_VALID = 1'b0;
      BUS_ADDR = 32'h0;
      BUS_FETCH = 1'b0;
      BUS_WRITE = 1'b0;
      BUS_SIZE = 2'h3;
      BUS_DATA = 32'h0;
      PAGE_SPACE_ID = 8'h0;
   end
   // idle lines carry no meaning, so keep them moving
   always @(negedge CLK) if (!BUS_VALID) begin
      BUS_ADDR <= ~BUS_ADDR;
      BUS_DATA <= ~BUS_DATA;
   end
   // one bus cycle; returns request and timing seen one cycle later
   task automatic cycle(input logic [31:0] a, input logic f, w, input sel_t s,
                        input logic [31:0] d, input logic [7:0] id, output logic [1:0] brk);
      @(posedge CLK);
      BUS_ADDR <= a;
      BUS_FETCH <= f;
      BUS_WRITE <= w;
      BUS_SIZE <= s;
      BUS_DATA <= d;
      PAGE_SPACE_ID <= id;
      BUS_VALID <= 1'b1;
      @(posedge CLK);
      BUS_VALID <= 1'b0;
      @(negedge CLK);
      brk = {BREAK_REQ, BREAK_AFTER};
   endtask
endmodule // cpu_bus_model

// [test_user_break_comparator.sv]
`timescale 1ns/100ps
`include "ubc_cfg.svh"
// self-checking bench for the break comparator
module test_user_break_comparator;
   import ubc_pkg::*;
   logic CLK = 0, RST = 1;
   logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
   logic [31:0] AWADDR = 0, WDATA = 0, ARADDR = 0, RDATA, BUS_ADDR, BUS_DATA, q, base;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, BREAK_REQ, BREAK_AFTER;
   logic BUS_VALID, BUS_FETCH, BUS_WRITE, e;
   logic [1:0] BRESP, RRESP, r, brk;
   sel_t BUS_SIZE, s;
   logic [7:0] PAGE_SPACE_ID;
   logic [31:0] rnd = 32'h20;
   logic [31:0] clr [3] = '{`OFS_CYCLE_A, `OFS_CYCLE_B, `OFS_COMMON};
   int bits [4] = '{9, 11, 31, 32};
   int fails = 0, checks_done = 0, m, i;

   always #5 CLK = ~CLK;
   // design and cpu-side partner; prot and strobes tied
   user_break_comparator u_user_break_comparator (.CLK(CLK), .RST(RST), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .AWADDR(AWADDR), .AWPROT(3'h0), .WVALID(WVALID), .WREADY(WREADY),
      .WDATA(WDATA), .WSTRB(4'hf), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
      .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR), .ARPROT(3'h0), .RVALID(RVALID),
      .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP), .BUS_VALID(BUS_VALID), .BUS_ADDR(BUS_ADDR),
      .BUS_FETCH(BUS_FETCH), .BUS_WRITE(BUS_WRITE), .BUS_SIZE(BUS_SIZE), .BUS_DATA(BUS_DATA),
      .PAGE_SPACE_ID(PAGE_SPACE_ID), .BREAK_REQ(BREAK_REQ), .BREAK_AFTER(BREAK_AFTER));
   cpu_bus_model u_cpu_bus_model (.CLK(CLK), .BUS_VALID(BUS_VALID), .BUS_ADDR(BUS_ADDR),
      .BUS_FETCH(BUS_FETCH), .BUS_WRITE(BUS_WRITE), .BUS_SIZE(BUS_SIZE), .BUS_DATA(BUS_DATA),
      .PAGE_SPACE_ID(PAGE_SPACE_ID), .BREAK_REQ(BREAK_REQ), .BREAK_AFTER(BREAK_AFTER));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // select code: 00 drops the term, 11 takes both kinds
   function automatic bit term(input logic [1:0] c, input bit first);
      return c == 2'h0 || c == 2'h3 || (c == 2'h1 && first) || (c == 2'h2 && !first);
   endfunction
   function automatic bit hit(input logic [5:0] c, input bit f, w, input logic [1:0] sz);
      return c != 6'h0 && term(c[5:4], f) && term(c[3:2], !w) && (c[1:0] == 2'h0 || c[1:0] == sz);
   endfunction

   task automatic chk_reg(input logic [31:0] g, x);
      checks_done++;
      if (g !== x) begin
         fails++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic chk_brk(input logic [1:0] g, x);
      chk_reg({30'h0, g}, {30'h0, x});
   endtask
   // one bus transfer; response ready held back a few cycles to stall the slave
   task automatic xfer(input bit rd, input logic [31:0] a, d, output logic [31:0] dq,
                       output logic [1:0] rq);
      bit aw, w, ar, b, rv, done;
      int n;
      @(posedge CLK);
      if (rd) begin
         ARADDR <= a;
         ARVALID <= 1'b1;
      end else begin
         AWADDR <= a;
         WDATA <= d;
         AWVALID <= 1'b1;
         WVALID <= 1'b1;
      end
      done = 0;
      for (n = 0; !done; n++) begin
         @(negedge CLK);
         aw = AWREADY;
         w = WREADY;
         ar = ARREADY;
         b = BVALID && BREADY;
         rv = RVALID && RREADY;
         dq = RDATA;
         rq = rd ? RRESP : BRESP;
         @(posedge CLK);
         if (aw) AWVALID <= 1'b0;
         if (w) WVALID <= 1'b0;
         if (ar) ARVALID <= 1'b0;
         BREADY <= !rd && n > 2 && !b;
         RREADY <= rd && n > 2 && !rv;
         done = b || rv;
      end
   endtask
   task automatic wr(input logic [31:0] a, d);
      xfer(1'b0, a, d, q, r);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // cut a hang short well past the expected run length
   initial begin
      #400000;
      fails++;
      test_done;
   end

   initial begin
      repeat (12) @(posedge CLK);
      RST <= 1'b0;
      foreach (clr[k]) begin
         xfer(1'b1, clr[k], 32'h0, q, r);
         chk_reg(q, 32'h0);
      end
      // unmapped places answer with a decode error
      xfer(1'b1, 32'h10, 32'h0, q, r);
      chk_reg(q, 32'h0);
      chk_reg({30'h0, r}, {30'h0, `RESP_DECERR});
      xfer(1'b0, 32'h10, 32'hffffffff, q, r);
      chk_reg({30'h0, r}, {30'h0, `RESP_DECERR});
      // address mask widths against single flipped bits
      base = lfsr(rnd);
      wr(`OFS_ADDR_A, base);
      xfer(1'b1, `OFS_ADDR_A, 32'h0, q, r);
      chk_reg(q, base);
      wr(`OFS_CYCLE_A, 32'h3f);
      for (m = 0; m < 4; m++) begin
         wr(`OFS_MASK_A, 32'h4 | m);
         for (i = 0; i < 4; i++) begin
            wr(`OFS_COMMON, 32'h0);
            u_cpu_bus_model.cycle(base ^ (32'h1 << bits[i]), 1'b0, 1'b0, 2'h3, rnd, 8'h0, brk);
            e = bits[i] == 32 || m == 3 || (m == 1 && bits[i] < 10) || (m == 2 && bits[i] < 12);
            chk_brk(brk, {e, 1'b0});
         end
      end
      // space id included, then masked
      wr(`OFS_SPACE_A, 32'h5a);
      for (i = 0; i < 3; i++) begin
         wr(`OFS_MASK_A, i == 2 ? 32'h7 : 32'h3);
         wr(`OFS_COMMON, 32'h0);
         u_cpu_bus_model.cycle(rnd, 1'b0, 1'b0, 2'h3, rnd, i == 0 ? 8'h5a : 8'h5b, brk);
         chk_brk(brk, {i != 1, 1'b0});
      end
      // random type, direction, size and fetch timing
      wr(`OFS_MASK_A, 32'h7);
      repeat (40) begin
         rnd = lfsr(rnd);
         s = rnd[9:8] == 2'h0 ? 2'h3 : rnd[9:8];
         wr(`OFS_CYCLE_A, {26'h0, rnd[5:0]});
         wr(`OFS_COMMON, {21'h0, rnd[10], 10'h0});
         u_cpu_bus_model.cycle(rnd, rnd[6], rnd[7], s, rnd, rnd[23:16], brk);
         e = hit(rnd[5:0], rnd[6], rnd[7], s);
         chk_brk(brk, {e, e & rnd[6] & rnd[10]});
      end
      // channel b data: upper half ignored on word, mask and enable
      wr(`OFS_CYCLE_A, 32'h0);
      wr(`OFS_CYCLE_B, 32'h26);
      wr(`OFS_MASK_B, 32'h7);
      wr(`OFS_DATA_B, 32'habcd1234);
      for (i = 0; i < 4; i++) begin
         wr(`OFS_DMASK_B, {31'h0, i == 2});
         wr(`OFS_COMMON, {24'h0, i != 3, 7'h0});
         u_cpu_bus_model.cycle(rnd, 1'b0, 1'b0, 2'h2, i == 0 ? 32'h1234 : 32'h1235, 8'h0, brk);
         chk_brk(brk, {i != 1, 1'b0});
      end
      // sequential: b alone, a arms, b fires, b again ignored since a has not matched anew
      wr(`OFS_CYCLE_A, 32'h17);
      wr(`OFS_CYCLE_B, 32'h2b);
      wr(`OFS_COMMON, 32'h8);
      for (i = 0; i < 4; i++) begin
         u_cpu_bus_model.cycle(rnd, i == 1, i != 1, 2'h3, rnd, 8'h0, brk);
         chk_brk(brk, {i == 2, 1'b0});
      end
      xfer(1'b1, `OFS_COMMON, 32'h0, q, r);
      chk_reg(q, 32'hc008);
      // reset in mid-run clears cycle and control registers, keeps addresses
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      foreach (clr[k]) begin
         xfer(1'b1, clr[k], 32'h0, q, r);
         chk_reg(q, 32'h0);
      end
      xfer(1'b1, `OFS_ADDR_A, 32'h0, q, r);
      chk_reg(q, base);
      test_done;
   end
endmodule // test_user_break_comparator
